// ### src/anp_pkg.sv
package anp_pkg;

  // Register offsets (word index on the management port)
  localparam logic [4:0] ANP_ADDR_W = 5'h05;
  localparam logic [4:0] ANP_OFS_ADV = 5'h04;
  localparam logic [4:0] ANP_OFS_LPA = 5'h05;
  localparam logic [4:0] ANP_OFS_EXP = 5'h06;
  localparam logic [4:0] ANP_OFS_NPT = 5'h07;
  localparam logic [4:0] ANP_OFS_NPR = 5'h08;
  localparam logic [4:0] ANP_OFS_IST = 5'h10;
  localparam logic [4:0] ANP_OFS_IMSK = 5'h11;

  // Field positions
  localparam int ANP_BIT_NP = 15;
  localparam int ANP_BIT_ACK = 14;
  localparam int ANP_BIT_RF = 13;
  localparam int ANP_BIT_MP = 13;
  localparam int ANP_BIT_ACK2 = 12;
  localparam int ANP_BIT_TOG = 11;
  localparam int ANP_BIT_PDF = 4;
  localparam int ANP_BIT_LPNP = 3;
  localparam int ANP_BIT_LNP = 2;
  localparam int ANP_BIT_PRX = 1;
  localparam int ANP_BIT_LPAN = 0;

  // Writable masks and reset values
  localparam logic [15:0] ANP_ADV_WMASK = 16'hbfff;
  localparam logic [15:0] ANP_ADV_RST = 16'h01e1;
  localparam logic [15:0] ANP_NPT_WMASK = 16'hb7ff;
  localparam logic [15:0] ANP_NPT_RST = 16'h2001;

  // Interrupt status bits
  localparam int ANP_IRQ_N = 3;
  localparam int ANP_IRQ_PDF = 0;
  localparam int ANP_IRQ_PAGE = 1;
  localparam int ANP_IRQ_NPSENT = 2;

endpackage : anp_pkg

// ### src/anp_latch_bit.sv
`timescale 1ns/1ps
`default_nettype none
module anp_latch_bit (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // Set event and read-clear
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      q_o
);
  logic q_reg;
  // Set outranks clear so an event in the clearing cycle survives
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      q_reg <= 1'b0;
    end else if (set_i) begin
      q_reg <= 1'b1;
    end else if (clr_i) begin
      q_reg <= 1'b0;
    end
  end
  assign q_o = q_reg;
endmodule : anp_latch_bit
`default_nettype wire

// ### src/anp_page_regs.sv
// Notes on behaviour
// RULE1 - Advert bit 15 requests next-page exchange
// RULE2 - Advert bits 11,10 advertise asymmetric/symmetric pause
// RULE3 - Advert bits 9:5 abilities, T4 defaults off
// RULE4 - Partner ability read-only: NP, ACK, RF
// RULE5 - Partner bits 11:5 abilities, 4:0 selector
// RULE6 - Parallel fault latches high until read
// RULE7 - Page received flag, resets zero
// RULE8 - Expansion bit 3 partner next-page capable
// RULE9 - Expansion bit 0 partner autoneg capable
// RULE10 - Expansion bit 2 one, 15:5 zero
// RULE11 - Next-page tx: more, message, code fields
// RULE12 - Next-page tx bit 12 second acknowledge
// RULE13 - Tx toggle read-only, inverse of last
// RULE14 - Partner next-page receive read-only fields
// RULE15 - Software loads next page after receipt
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module anp_page_regs
  import anp_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  // Register port
  input  wire logic [ANP_ADDR_W-1:0] reg_addr_i,
  input  wire logic [15:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [15:0]           reg_rdata_o,
  // Arbitration side: transmitted pages
  output logic      [15:0]           base_page_o,
  output logic      [15:0]           next_page_o,
  input  wire logic                  page_sent_i,
  // Arbitration side: received pages and status
  input  wire logic                  base_rx_i,
  input  wire logic                  next_rx_i,
  input  wire logic [15:0]           link_codeword_i,
  input  wire logic                  link_partner_an_i,
  input  wire logic                  par_det_fault_i,
  // Interrupt
  output logic                       irq_o
);
  import anp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode
  wire sel_adv  = (reg_addr_i == ANP_OFS_ADV);
  wire sel_lpa  = (reg_addr_i == ANP_OFS_LPA);
  wire sel_exp  = (reg_addr_i == ANP_OFS_EXP);
  wire sel_npt  = (reg_addr_i == ANP_OFS_NPT);
  wire sel_npr  = (reg_addr_i == ANP_OFS_NPR);
  wire sel_ist  = (reg_addr_i == ANP_OFS_IST);
  wire sel_imsk = (reg_addr_i == ANP_OFS_IMSK);
  wire wr_adv   = reg_wr_i & sel_adv;
  wire wr_npt   = reg_wr_i & sel_npt;
  wire wr_imsk  = reg_wr_i & sel_imsk;
  wire rd_exp   = reg_rd_i & sel_exp;
  wire rd_ist   = reg_rd_i & sel_ist;

  ////////////////////////////////////////////////////////////////////////////////
  // Local registers
  logic [15:0] adv_reg;
  logic [15:0] npt_reg;
  logic        tog_reg;
  logic [15:0] lpa_reg;
  logic [15:0] npr_reg;
  logic        lpnp_reg;
  logic [ANP_IRQ_N-1:0] imsk_reg;

  // Bit 14 is reserved read-only; bit 12 is reserved but writable
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      adv_reg <= ANP_ADV_RST; // [RULE1] [RULE2] [RULE3]
    end else if (wr_adv) begin
      adv_reg <= reg_wdata_i & ANP_ADV_WMASK; // [RULE1] [RULE2] [RULE3]
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      npt_reg <= ANP_NPT_RST; // [RULE11]
    end else if (wr_npt) begin
      npt_reg <= reg_wdata_i & ANP_NPT_WMASK; // [RULE11] [RULE12]
    end
  end

  // Toggle resets to 0 and flips each time a next page goes out
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tog_reg <= 1'b0;
    end else if (page_sent_i) begin
      tog_reg <= ~next_page_o[ANP_BIT_TOG]; // [RULE13]
    end
  end

  assign base_page_o = adv_reg;
  assign next_page_o = {npt_reg[15:12], tog_reg, npt_reg[10:0]}; // [RULE12] [RULE13]

  ////////////////////////////////////////////////////////////////////////////////
  // Received pages
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      lpa_reg  <= 16'h0000;
      lpnp_reg <= 1'b0;
    end else if (base_rx_i) begin
      lpa_reg  <= link_codeword_i; // [RULE4] [RULE5]
      lpnp_reg <= link_codeword_i[ANP_BIT_NP]; // [RULE8]
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      npr_reg <= 16'h0000;
    end else if (next_rx_i) begin
      npr_reg <= link_codeword_i; // [RULE14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Expansion flags: both clear on a read of the expansion register
  wire pdf_q;
  wire prx_q;
  wire page_rx = base_rx_i | next_rx_i;

  anp_latch_bit u_pdf (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .set_i     (par_det_fault_i), // [RULE6]
    .clr_i     (rd_exp),
    .q_o       (pdf_q)
  );

  anp_latch_bit u_prx (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .set_i     (page_rx), // [RULE7]
    .clr_i     (rd_exp),
    .q_o       (prx_q)
  );

  logic an_reg;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      an_reg <= 1'b0;
    end else begin
      an_reg <= link_partner_an_i; // [RULE9]
    end
  end

  wire [15:0] exp_val = {11'h000, pdf_q, lpnp_reg, 1'b1, prx_q, an_reg}; // [RULE10]

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, read-clear, masked level output
  wire [ANP_IRQ_N-1:0] irq_ev;
  wire [ANP_IRQ_N-1:0] ist_q;
  assign irq_ev[ANP_IRQ_PDF]    = par_det_fault_i;
  assign irq_ev[ANP_IRQ_PAGE]   = page_rx;
  assign irq_ev[ANP_IRQ_NPSENT] = page_sent_i;

  genvar gi;
  generate
    for (gi = 0; gi < ANP_IRQ_N; gi++) begin : g_ist
      anp_latch_bit u_ist (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .set_i     (irq_ev[gi]),
        .clr_i     (rd_ist),
        .q_o       (ist_q[gi])
      );
    end
  endgenerate

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      imsk_reg <= '0;
    end else if (wr_imsk) begin
      imsk_reg <= reg_wdata_i[ANP_IRQ_N-1:0];
    end
  end

  assign irq_o = |(ist_q & imsk_reg);

  ////////////////////////////////////////////////////////////////////////////////
  // Read path: data one cycle after the strobe, zero for unmapped addresses
  wire [15:0] rd_mux =
    sel_adv  ? adv_reg :
    sel_lpa  ? lpa_reg :
    sel_exp  ? exp_val :
    sel_npt  ? next_page_o :
    sel_npr  ? npr_reg :
    sel_ist  ? {13'h0000, ist_q} :
    sel_imsk ? {13'h0000, imsk_reg} : 16'h0000;

  logic [15:0] rdata_reg;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_reg <= 16'h0000;
    end else if (reg_rd_i) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= 16'h0000;
    end
  end
  assign reg_rdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_adv_np;
    @(posedge sys_clk_i) disable iff (rst_i)
      wr_adv |=> base_page_o[ANP_BIT_NP] == $past(reg_wdata_i[ANP_BIT_NP]);
  endproperty
  a_adv_np: assert property (p_adv_np) else $error("Next-page request not stored"); // [RULE1]

  property p_adv_pause;
    @(posedge sys_clk_i) disable iff (rst_i)
      !wr_adv |=> $stable(base_page_o[11:10]);
  endproperty
  a_adv_pause: assert property (p_adv_pause) else $error("Pause bits moved unwritten"); // [RULE2]

  property p_adv_rst;
    @(posedge sys_clk_i) $fell(rst_i) |-> base_page_o[9:5] == 5'h0f;
  endproperty
  a_adv_rst: assert property (p_adv_rst) else $error("Ability defaults wrong"); // [RULE3]

  property p_lpa_ro;
    @(posedge sys_clk_i) disable iff (rst_i)
      !base_rx_i |=> $stable(lpa_reg);
  endproperty
  a_lpa_ro: assert property (p_lpa_ro) else $error("Partner ability changed"); // [RULE4]

  property p_lpa_cap;
    @(posedge sys_clk_i) disable iff (rst_i)
      base_rx_i |=> lpa_reg[11:0] == $past(link_codeword_i[11:0]);
  endproperty
  a_lpa_cap: assert property (p_lpa_cap) else $error("Partner abilities not captured"); // [RULE5]

  property p_pdf;
    @(posedge sys_clk_i) disable iff (rst_i)
      par_det_fault_i ##1 !rd_exp |=> exp_val[ANP_BIT_PDF];
  endproperty
  a_pdf: assert property (p_pdf) else $error("Fault flag lost before read"); // [RULE6]

  property p_prx;
    @(posedge sys_clk_i) disable iff (rst_i)
      page_rx |=> exp_val[ANP_BIT_PRX];
  endproperty
  a_prx: assert property (p_prx) else $error("Page flag not set"); // [RULE7]

  property p_exp_fixed;
    @(posedge sys_clk_i) disable iff (rst_i)
      reg_rd_i && sel_exp |=> reg_rdata_o[15:5] == 11'h000 && reg_rdata_o[ANP_BIT_LNP];
  endproperty
  a_exp_fixed: assert property (p_exp_fixed) else $error("Expansion fixed bits wrong"); // [RULE10]

  property p_tog;
    @(posedge sys_clk_i) disable iff (rst_i)
      page_sent_i |=> next_page_o[ANP_BIT_TOG] != $past(next_page_o[ANP_BIT_TOG]);
  endproperty
  a_tog: assert property (p_tog) else $error("Toggle did not flip"); // [RULE13]

  property p_npr;
    @(posedge sys_clk_i) disable iff (rst_i)
      next_rx_i ##1 !next_rx_i[*2] |-> npr_reg == $past(link_codeword_i, 2);
  endproperty
  a_npr: assert property (p_npr) else $error("Next page receive not held"); // [RULE14]

  property p_npt;
    @(posedge sys_clk_i) disable iff (rst_i)
      wr_npt |=> next_page_o[12] == $past(reg_wdata_i[12]) && next_page_o[14] == 1'b0;
  endproperty
  a_npt: assert property (p_npt) else $error("Next page tx fields wrong"); // [RULE11] [RULE12]

  property p_adv_fld;
    @(posedge sys_clk_i) disable iff (rst_i)
      wr_adv |=> base_page_o[14] == 1'b0 && base_page_o[11:5] == $past(reg_wdata_i[11:5]);
  endproperty
  a_adv_fld: assert property (p_adv_fld) else $error("Abilities not stored"); // [RULE2] [RULE3]

  property p_adv_clr;
    @(posedge sys_clk_i)
      $fell(rst_i) |-> !base_page_o[ANP_BIT_NP] && base_page_o[11:10] == 2'b00;
  endproperty
  a_adv_clr: assert property (p_adv_clr) else $error("Defaults not clear"); // [RULE1] [RULE2]

  property p_lpa_flg;
    @(posedge sys_clk_i) disable iff (rst_i)
      base_rx_i |=> lpa_reg[15:13] == $past(link_codeword_i[15:13]);
  endproperty
  a_lpa_flg: assert property (p_lpa_flg) else $error("Partner flags wrong"); // [RULE4]

  property p_lpnp;
    @(posedge sys_clk_i) disable iff (rst_i)
      base_rx_i |=> exp_val[ANP_BIT_LPNP] == $past(link_codeword_i[ANP_BIT_NP]);
  endproperty
  a_lpnp: assert property (p_lpnp) else $error("Next-page capable wrong"); // [RULE8]

  property p_lpnp_hld;
    @(posedge sys_clk_i) disable iff (rst_i)
      !base_rx_i |=> $stable(exp_val[ANP_BIT_LPNP]);
  endproperty
  a_lpnp_hld: assert property (p_lpnp_hld) else $error("Capable flag moved"); // [RULE8]

  property p_an;
    @(posedge sys_clk_i) disable iff (rst_i)
      1'b1 |=> exp_val[ANP_BIT_LPAN] == $past(link_partner_an_i);
  endproperty
  a_an: assert property (p_an) else $error("Autoneg flag wrong"); // [RULE9]

  property p_exp_clr;
    @(posedge sys_clk_i) disable iff (rst_i)
      rd_exp && !par_det_fault_i && !page_rx
      |=> !exp_val[ANP_BIT_PDF] && !exp_val[ANP_BIT_PRX];
  endproperty
  a_exp_clr: assert property (p_exp_clr) else $error("Flags not cleared"); // [RULE6] [RULE7]

  property p_pdf_hld;
    @(posedge sys_clk_i) disable iff (rst_i)
      exp_val[ANP_BIT_PDF] && !rd_exp |=> exp_val[ANP_BIT_PDF];
  endproperty
  a_pdf_hld: assert property (p_pdf_hld) else $error("Fault flag lost"); // [RULE6]

  property p_exp_rst;
    @(posedge sys_clk_i) $fell(rst_i) |-> exp_val == 16'h0004;
  endproperty
  a_exp_rst: assert property (p_exp_rst) else $error("Bad defaults"); // [RULE7] [RULE9] [RULE10]

  property p_tog_hld;
    @(posedge sys_clk_i) disable iff (rst_i)
      !page_sent_i |=> $stable(next_page_o[ANP_BIT_TOG]);
  endproperty
  a_tog_hld: assert property (p_tog_hld) else $error("Toggle moved"); // [RULE13]

  property p_npt_rst;
    @(posedge sys_clk_i) $fell(rst_i) |-> next_page_o == ANP_NPT_RST;
  endproperty
  a_npt_rst: assert property (p_npt_rst) else $error("Bad defaults"); // [RULE11] [RULE13]

  property p_npt_fld;
    @(posedge sys_clk_i) disable iff (rst_i)
      wr_npt |=> next_page_o[ANP_BIT_NP] == $past(reg_wdata_i[ANP_BIT_NP])
        && next_page_o[ANP_BIT_MP] == $past(reg_wdata_i[ANP_BIT_MP])
        && next_page_o[10:0] == $past(reg_wdata_i[10:0]);
  endproperty
  a_npt_fld: assert property (p_npt_fld) else $error("Next page not stored"); // [RULE11]

  property p_npr_ro;
    @(posedge sys_clk_i) disable iff (rst_i)
      !next_rx_i |=> $stable(npr_reg);
  endproperty
  a_npr_ro: assert property (p_npr_ro) else $error("Receive register moved"); // [RULE14]

endmodule : anp_page_regs
`default_nettype wire

// ### tb/anp_lp_model.sv
`timescale 1ns/1ps
`default_nettype none
module anp_lp_model (
  // Clock
  input  wire logic        sys_clk_i,
  // Received page strobes and codeword
  output logic             base_rx_o,
  output logic             next_rx_o,
  output logic      [15:0] link_codeword_o,
  output logic             link_partner_an_o
);
  initial begin
    base_rx_o         = 1'b0;
    next_rx_o         = 1'b0;
    link_codeword_o   = 16'h0000;
    link_partner_an_o = 1'b0;
  end
  ////////////////////////////////////////
  // Codeword is only valid with its strobe; flip it after so stale data never matches
  task automatic send_page(input logic nxt, input logic [15:0] cw);
    @(posedge sys_clk_i);
    link_partner_an_o <= 1'b1;
    link_codeword_o   <= cw;
    base_rx_o         <= ~nxt;
    next_rx_o         <= nxt;
    @(posedge sys_clk_i);
    base_rx_o         <= 1'b0;
    next_rx_o         <= 1'b0;
    link_codeword_o   <= ~cw;
  endtask : send_page
endmodule : anp_lp_model
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
  import anp_pkg::*;
  logic        sys_clk, rst, wr, rd, sent, pdf, brx, nrx, an, irq;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, bpage, npage, cw;
  int          bad_count, n_compared;

  anp_page_regs DUT (.sys_clk_i(sys_clk), .rst_i(rst), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .base_page_o(bpage), .next_page_o(npage), .page_sent_i(sent), .base_rx_i(brx),
    .next_rx_i(nrx), .link_codeword_i(cw), .link_partner_an_i(an),
    .par_det_fault_i(pdf), .irq_o(irq));
  anp_lp_model lp (.sys_clk_i(sys_clk), .base_rx_o(brx), .next_rx_o(nrx),
    .link_codeword_o(cw), .link_partner_an_o(an));

  ////////////////////////////////////////
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask : wr_reg
  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e, input string n);
    @(posedge sys_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd   <= 1'b0;
    #1 `CHK(n, e, rdata)
  endtask : rd_chk
  task automatic finish_test;
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////
  task automatic t_reset;
    rd_chk(ANP_OFS_ADV, 16'h01e1, "adv");
    rd_chk(ANP_OFS_LPA, 16'h0000, "lpa");
    rd_chk(ANP_OFS_EXP, 16'h0004, "exp");
    rd_chk(ANP_OFS_NPT, 16'h2001, "npt");
    rd_chk(ANP_OFS_NPR, 16'h0000, "npr");
    rd_chk(5'h1f, 16'h0000, "unmapped");
  endtask : t_reset
  task automatic t_adv;
    wr_reg(ANP_OFS_ADV, 16'hffff);
    rd_chk(ANP_OFS_ADV, 16'hbfff, "adv");
    `CHK("base", 16'hbfff, bpage)
    wr_reg(ANP_OFS_ADV, 16'h0000);
    rd_chk(ANP_OFS_ADV, 16'h0000, "adv");
  endtask : t_adv
  task automatic t_base;
    wr_reg(ANP_OFS_LPA, 16'hffff);
    rd_chk(ANP_OFS_LPA, 16'h0000, "lpa");
    lp.send_page(1'b0, 16'he5e1);
    rd_chk(ANP_OFS_LPA, 16'he5e1, "lpa");
    rd_chk(ANP_OFS_EXP, 16'h000f, "exp");
    rd_chk(ANP_OFS_EXP, 16'h000d, "exp");
  endtask : t_base
  task automatic t_fault;
    @(posedge sys_clk) pdf <= 1'b1;
    @(posedge sys_clk) pdf <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd_chk(ANP_OFS_EXP, 16'h001d, "exp");
    rd_chk(ANP_OFS_EXP, 16'h000d, "exp");
  endtask : t_fault
  task automatic t_npt;
    wr_reg(ANP_OFS_NPT, 16'hffff);
    rd_chk(ANP_OFS_NPT, 16'hb7ff, "npt");
    `CHK("next", 16'hb7ff, npage)
    @(posedge sys_clk) sent <= 1'b1;
    @(posedge sys_clk) sent <= 1'b0;
    rd_chk(ANP_OFS_NPT, 16'hbfff, "npt");
    `CHK("next", 16'hbfff, npage)
    wr_reg(ANP_OFS_NPT, 16'h0000);
    rd_chk(ANP_OFS_NPT, 16'h0800, "npt");
  endtask : t_npt
  task automatic t_npr;
    lp.send_page(1'b1, 16'h5a5a);
    rd_chk(ANP_OFS_EXP, 16'h000f, "exp");
    wr_reg(ANP_OFS_NPR, 16'h0000);
    rd_chk(ANP_OFS_NPR, 16'h5a5a, "npr");
    // Next page loaded only once receipt was seen
    wr_reg(ANP_OFS_NPT, 16'h2001);
  endtask : t_npr
  task automatic t_irq;
    rd_chk(ANP_OFS_IST, 16'h0007, "ist");
    @(posedge sys_clk) pdf <= 1'b1;
    @(posedge sys_clk) pdf <= 1'b0;
    #1 `CHK("irq", 1'b0, irq)
    wr_reg(ANP_OFS_IMSK, 16'h0001);
    #1 `CHK("irq", 1'b1, irq)
    rd_chk(ANP_OFS_IST, 16'h0001, "ist");
    `CHK("irq", 1'b0, irq)
  endtask : t_irq
  // Reset in mid-run must restore the adv, npt, lpa and npr defaults and clear the exp flags, not only the power-up ones
  task automatic t_rerun;
    wr_reg(ANP_OFS_ADV, 16'hbc00);
    @(posedge sys_clk) rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(ANP_OFS_ADV, 16'h01e1, "adv");
    rd_chk(ANP_OFS_NPT, 16'h2001, "npt");
    rd_chk(ANP_OFS_EXP, 16'h0005, "exp");
    rd_chk(ANP_OFS_LPA, 16'h0000, "lpa");
    rd_chk(ANP_OFS_NPR, 16'h0000, "npr");
    `CHK("irq", 1'b0, irq)
  endtask : t_rerun
  ////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    {rst, wr, rd, sent, pdf} = 5'h10;
    addr  = 5'h00;
    wdata = 16'h0000;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_adv();
    t_base();
    t_fault();
    t_npt();
    t_npr();
    t_irq();
    t_rerun();
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
